// file: logic/tdmcfg_pkg.sv
// tdmcfg package: register map, field layout, codes and state types
package tdmcfg_pkg;

    // ========================================
    // register map and layout
    localparam int          ADDR_W        = 8;
    localparam int          STREAMS       = 16;
    localparam logic [7:0]  ADDR_BP_CFG   = 8'h00;
    localparam logic [7:0]  ADDR_LB_CFG   = 8'h04;
    localparam logic [15:0] BP_CFG_RESET  = 16'h0000;
    localparam logic [15:0] LB_CFG_RESET  = 16'h0000;
    localparam logic [15:0] BP_WR_MASK    = 16'h0fff;
    localparam int          BP_FP_POS     = 0;
    localparam int          BP_SMPL_POS   = 2;
    localparam int          BP_RATE_POS   = 4;
    localparam int          BP_DERIVE_POS = 6;
    localparam int          BP_TYPE_POS   = 7;
    localparam int          BP_MASTER_POS = 8;
    localparam int          BP_ALT_POS    = 9;
    localparam int          BP_HOLD_POS   = 11;
    localparam int          LB_FP_POS     = 0;
    localparam int          LB_SMPL_POS   = 2;
    localparam int          LB_DIV_POS    = 6;
    localparam int          LB_TOLOC_POS  = 8;
    localparam int          LB_TOBP_POS   = 12;

    // ========================================
    // field codes
    localparam logic [1:0]  FP_LOW_HALF   = 2'h0;
    localparam logic [1:0]  FP_HIGH_FULL  = 2'h3;
    localparam logic [1:0]  SMPL_END      = 2'h0;
    localparam logic [1:0]  SMPL_RSVD     = 2'h3;
    localparam logic [1:0]  RATE_2M       = 2'h0;
    localparam logic [1:0]  RATE_4M       = 2'h1;
    localparam logic [1:0]  RATE_8M       = 2'h2;
    localparam logic [7:0]  SLOTS_2M      = 8'h20;
    localparam logic [7:0]  SLOTS_4M      = 8'h40;
    localparam logic [7:0]  SLOTS_8M      = 8'h80;
    localparam logic [1:0]  DIV_1         = 2'h0;
    localparam logic [1:0]  DIV_2         = 2'h1;
    localparam logic [1:0]  DIV_4         = 2'h2;
    localparam logic [1:0]  PIN_A_FAIL_IN = 2'h3;
    localparam int          ACK_BIT       = 1;

    // ========================================
    // types
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK  = 2'b10
    } tdmcfg_bus_e;

    typedef struct packed {
        logic dclk_oe;
        logic bclk_oe;
        logic fp_oe;
        logic fp_high;
        logic diff_clk;
        logic derive;
        logic fast_hold;
        logic mc_en;
    } tdmcfg_ctl_s;

    typedef struct packed {
        tdmcfg_bus_e          bus;
        logic [15:0]          bp_cfg;
        logic [15:0]          lb_cfg;
        logic [31:0]          rdata;
        tdmcfg_ctl_s          ctl;
        logic [1:0]           bp_smpl;
        logic [1:0]           lb_smpl;
        logic [7:0]           slots;
        logic                 lb_fp_high;
        logic                 pin_a_out;
        logic                 pin_a_oe;
        logic                 bclk_q;
        logic [1:0]           edge_cnt;
        logic                 loc_clk;
        logic                 loc_out;
        logic [STREAMS-1:0]   bp_out;
        logic [STREAMS-1:0]   bp_oe;
    } tdmcfg_state_s;

endpackage

// file: logic/tdmcfg_top.sv
// tdmcfg_top: backplane and local bus timing configuration block
//
// Notes on behaviour
// - frame pulse code 00 active-low half period, 11 active-high full period
// - active-high pulse needs master or no clock derivation; message channel off
// - sample point 00 end, 01 three quarters, 10 half, 11 reserved
// - rate 00 2MHz/32 slots, 01 4MHz/64, 10 8MHz/128, 11 reserved
// - derive bit 0 normal bit clock, 1 derive it from double-rate clock
// - slave with derivation keeps bit clock pin undriven
// - clock type picks single-ended or differential slave clock input
// - master select drives double-rate clock, bit clock, frame pulse
// - alternate master drives clocks only while clock failure is high
// - alternate master needs general pin A configured as clock-failure line
// - hold bit 0 fast bus timing, 1 slow bus timing
// - backplane bits 15:12 read zero
// - local frame pulse uses backplane encoding on local bit clock
// - local division 00 direct, 01 by two, 10 by four
// - four-bit field picks backplane input routed to local output
// - four-bit field picks backplane output carrying local input
// - pin A as clock-failure line driven low while master, else input
`timescale 1ns/1ns

module tdmcfg_top
    import tdmcfg_pkg::*;
(
    input  wire logic                              core_clk,
    input  wire logic                              rst,
    input  wire logic                              wb_cyc_i,
    input  wire logic                              wb_stb_i,
    input  wire logic                              wb_we_i,
    input  wire logic [tdmcfg_pkg::ADDR_W-1:0]     wb_adr_i,
    input  wire logic [3:0]                        wb_sel_i,
    input  wire logic [31:0]                       wb_dat_i,
    output logic [31:0]                            wb_dat_o,
    output logic                                   wb_ack_o,
    input  wire logic                              clock_failure_status,
    input  wire logic [1:0]                        general_pin_a_config,
    input  wire logic                              bit_clock_in,
    input  wire logic [tdmcfg_pkg::STREAMS-1:0]    backplane_serial_in,
    input  wire logic                              local_serial_input,
    output tdmcfg_pkg::tdmcfg_ctl_s                ctl,
    output logic [1:0]                             backplane_sample_point,
    output logic [1:0]                             local_sample_point,
    output logic [7:0]                             slots_per_frame,
    output logic                                   local_frame_pulse_high,
    output logic                                   general_pin_a_out,
    output logic                                   general_pin_a_oe,
    output logic                                   local_bit_clock,
    output logic                                   local_serial_output,
    output logic [tdmcfg_pkg::STREAMS-1:0]         backplane_serial_out,
    output logic [tdmcfg_pkg::STREAMS-1:0]         backplane_serial_oe
);
    import tdmcfg_pkg::*;

    tdmcfg_state_s state_r;
    tdmcfg_state_s state_nxt;

    logic       eff_master;
    logic       bclk_rise;
    logic       req;
    logic [3:0] to_loc_sel;
    logic [3:0] to_bp_sel;
    logic [1:0] bp_fp;
    logic [1:0] lb_fp;

    // ========================================
    // decode helpers
    assign bp_fp      = state_r.bp_cfg[BP_FP_POS +: 2];
    assign lb_fp      = state_r.lb_cfg[LB_FP_POS +: 2];
    assign to_loc_sel = state_r.lb_cfg[LB_TOLOC_POS +: 4];
    assign to_bp_sel  = state_r.lb_cfg[LB_TOBP_POS +: 4];
    assign bclk_rise  = bit_clock_in & ~state_r.bclk_q;
    assign req        = wb_cyc_i & wb_stb_i;
    assign eff_master = state_r.bp_cfg[BP_MASTER_POS]
                      | (state_r.bp_cfg[BP_ALT_POS]
                         & (general_pin_a_config == PIN_A_FAIL_IN)
                         & clock_failure_status);

    // ========================================
    // next state
    always_comb
    begin
        state_nxt = state_r;

        // wishbone slave, one ack per request, registered the cycle after it is seen
        unique case (state_r.bus)
            BUS_IDLE:
            begin
                if (req)
                begin
                    state_nxt.bus   = BUS_ACK;
                    state_nxt.rdata = 32'h0000_0000;
                    if (wb_adr_i == ADDR_BP_CFG)
                    begin
                        if (wb_we_i)
                        begin
                            // upper nibble held at zero
                            if (wb_sel_i[0])
                                state_nxt.bp_cfg[7:0] = wb_dat_i[7:0];
                            if (wb_sel_i[1])
                                state_nxt.bp_cfg[15:8] = wb_dat_i[15:8] & BP_WR_MASK[15:8];
                        end
                        state_nxt.rdata = {16'h0000, state_r.bp_cfg & BP_WR_MASK};
                    end
                    else if (wb_adr_i == ADDR_LB_CFG)
                    begin
                        if (wb_we_i)
                        begin
                            if (wb_sel_i[0])
                                state_nxt.lb_cfg[7:0] = wb_dat_i[7:0];
                            if (wb_sel_i[1])
                                state_nxt.lb_cfg[15:8] = wb_dat_i[15:8];
                        end
                        state_nxt.rdata = {16'h0000, state_r.lb_cfg};
                    end
                end
            end
            BUS_ACK:
            begin
                state_nxt.bus = BUS_IDLE;
            end
            default:
            begin
                state_nxt.bus = BUS_IDLE;
            end
        endcase

        // clock and frame pulse drivers
        state_nxt.ctl.dclk_oe  = eff_master;
        state_nxt.ctl.fp_oe    = eff_master;
        state_nxt.ctl.fp_high  = (bp_fp == FP_HIGH_FULL);
        // active-high pulse in slave mode forbids derivation
        state_nxt.ctl.derive   = state_r.bp_cfg[BP_DERIVE_POS]
                               & ~(state_nxt.ctl.fp_high & ~eff_master);
        state_nxt.ctl.bclk_oe  = eff_master;
        state_nxt.ctl.diff_clk = state_r.bp_cfg[BP_TYPE_POS] & ~eff_master;
        state_nxt.ctl.fast_hold = ~state_r.bp_cfg[BP_HOLD_POS];
        state_nxt.ctl.mc_en    = ~state_nxt.ctl.fp_high;

        // sampling points, reserved code falls back to end of bit
        state_nxt.bp_smpl = state_r.bp_cfg[BP_SMPL_POS +: 2];
        if (state_nxt.bp_smpl == SMPL_RSVD)
            state_nxt.bp_smpl = SMPL_END;
        state_nxt.lb_smpl = state_r.lb_cfg[LB_SMPL_POS +: 2];
        if (state_nxt.lb_smpl == SMPL_RSVD)
            state_nxt.lb_smpl = SMPL_END;

        // frame length, reserved rate treated as lowest rate
        unique case (state_r.bp_cfg[BP_RATE_POS +: 2])
            RATE_4M: state_nxt.slots = SLOTS_4M;
            RATE_8M: state_nxt.slots = SLOTS_8M;
            default: state_nxt.slots = SLOTS_2M;
        endcase

        state_nxt.lb_fp_high = (lb_fp == FP_HIGH_FULL);

        // general pin A in clock-failure role
        state_nxt.pin_a_out = 1'b0;
        state_nxt.pin_a_oe  = (general_pin_a_config == PIN_A_FAIL_IN)
                            & eff_master;

        // local bit clock divider
        state_nxt.bclk_q = bit_clock_in;
        unique case (state_r.lb_cfg[LB_DIV_POS +: 2])
            DIV_2:
            begin
                if (bclk_rise)
                    state_nxt.loc_clk = ~state_r.loc_clk;
            end
            DIV_4:
            begin
                if (bclk_rise)
                begin
                    state_nxt.edge_cnt = 2'(state_r.edge_cnt + 2'h1);
                    if (state_r.edge_cnt[0])
                        state_nxt.loc_clk = ~state_r.loc_clk;
                end
            end
            default:
            begin
                state_nxt.loc_clk = bit_clock_in;
            end
        endcase

        // stream routing
        state_nxt.loc_out = backplane_serial_in[to_loc_sel];
        state_nxt.bp_out  = {STREAMS{local_serial_input}};
        state_nxt.bp_oe   = STREAMS'(1) << to_bp_sel;
    end

    // ========================================
    // state register
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            state_r          <= '0;
            state_r.bus      <= BUS_IDLE;
            state_r.bp_cfg   <= BP_CFG_RESET;
            state_r.lb_cfg   <= LB_CFG_RESET;
            state_r.slots    <= SLOTS_2M;
            state_r.ctl.mc_en <= 1'b1;
            state_r.ctl.fast_hold <= 1'b1;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    // ========================================
    // outputs
    assign wb_dat_o               = state_r.rdata;
    assign wb_ack_o               = state_r.bus[ACK_BIT];
    assign ctl                    = state_r.ctl;
    assign backplane_sample_point = state_r.bp_smpl;
    assign local_sample_point     = state_r.lb_smpl;
    assign slots_per_frame        = state_r.slots;
    assign local_frame_pulse_high = state_r.lb_fp_high;
    assign general_pin_a_out      = state_r.pin_a_out;
    assign general_pin_a_oe       = state_r.pin_a_oe;
    assign local_bit_clock        = state_r.loc_clk;
    assign local_serial_output    = state_r.loc_out;
    assign backplane_serial_out   = state_r.bp_out;
    assign backplane_serial_oe    = state_r.bp_oe;

    // ========================================
    // assertions
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    AST_ACK_ONE_CYCLE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

    AST_ACK_AFTER_REQ: assert property ((req && !wb_ack_o) |=> wb_ack_o)
        else $error("request not answered next cycle");

    AST_BP_UPPER_ZERO: assert property (
        (wb_ack_o && $past(wb_adr_i) == ADDR_BP_CFG) |-> wb_dat_o[31:12] == 20'h00000)
        else $error("backplane upper bits not zero");

    AST_RATE_8M: assert property (
        (state_r.bp_cfg[BP_RATE_POS +: 2] == RATE_8M) |=> slots_per_frame == SLOTS_8M)
        else $error("8 MHz rate not giving 128 slots");

    AST_SLAVE_UNDRIVEN: assert property (
        (!state_r.bp_cfg[BP_MASTER_POS] && !state_r.bp_cfg[BP_ALT_POS])
        |=> !ctl.dclk_oe && !ctl.bclk_oe && !ctl.fp_oe)
        else $error("slave drives clock lines");

    AST_MASTER_DRIVES: assert property (
        state_r.bp_cfg[BP_MASTER_POS] |=> ctl.dclk_oe && ctl.bclk_oe && ctl.fp_oe)
        else $error("master not driving clock lines");

    AST_ALT_TAKEOVER: assert property (
        (state_r.bp_cfg[BP_ALT_POS] && general_pin_a_config == PIN_A_FAIL_IN
         && clock_failure_status) |=> ctl.dclk_oe)
        else $error("alternate master did not take over");

    AST_ALT_NEEDS_PIN: assert property (
        (!state_r.bp_cfg[BP_MASTER_POS] && general_pin_a_config != PIN_A_FAIL_IN)
        |=> !ctl.dclk_oe)
        else $error("alternate master active without clock-failure pin");

    AST_PIN_A_LOW: assert property (
        (state_r.bp_cfg[BP_MASTER_POS] && general_pin_a_config == PIN_A_FAIL_IN)
        |=> general_pin_a_oe && !general_pin_a_out)
        else $error("clock-failure pin not driven low by master");

    AST_HIGH_FP_NO_DERIVE: assert property (
        (bp_fp == FP_HIGH_FULL && !eff_master) |=> !ctl.derive && !ctl.mc_en)
        else $error("derivation or message channel on with high pulse");

    AST_DIV_DIRECT: assert property (
        (state_r.lb_cfg[LB_DIV_POS +: 2] == DIV_1) |=> local_bit_clock == $past(bit_clock_in))
        else $error("direct local clock mismatch");

    AST_ROUTE_LOCAL: assert property (
        1'b1 |=> local_serial_output == $past(backplane_serial_in[to_loc_sel]))
        else $error("wrong stream routed to local output");

    AST_ROUTE_BP: assert property (
        1'b1 |=> backplane_serial_oe == (STREAMS'(1) << $past(to_bp_sel)))
        else $error("wrong backplane stream enabled");

    AST_BP_SAMPLE: assert property (
        (state_r.bp_cfg[BP_SMPL_POS +: 2] != SMPL_RSVD)
        |=> backplane_sample_point == $past(state_r.bp_cfg[BP_SMPL_POS +: 2]))
        else $error("backplane sample point not taken from field");

    AST_LB_SAMPLE: assert property (
        (state_r.lb_cfg[LB_SMPL_POS +: 2] != SMPL_RSVD)
        |=> local_sample_point == $past(state_r.lb_cfg[LB_SMPL_POS +: 2]))
        else $error("local sample point not taken from field");

    AST_SAMPLE_RSVD: assert property (
        (state_r.bp_cfg[BP_SMPL_POS +: 2] == SMPL_RSVD) |=> backplane_sample_point == SMPL_END)
        else $error("reserved sample code not mapped to end of bit");

    AST_RATE_2M: assert property (
        (state_r.bp_cfg[BP_RATE_POS +: 2] == RATE_2M) |=> slots_per_frame == SLOTS_2M)
        else $error("2 MHz rate not giving 32 slots");

    AST_RATE_4M: assert property (
        (state_r.bp_cfg[BP_RATE_POS +: 2] == RATE_4M) |=> slots_per_frame == SLOTS_4M)
        else $error("4 MHz rate not giving 64 slots");

    AST_RATE_RSVD: assert property (
        (state_r.bp_cfg[BP_RATE_POS +: 2] == 2'h3) |=> slots_per_frame == SLOTS_2M)
        else $error("reserved rate not mapped to 32 slots");

    AST_DERIVE_PIN_IDLE: assert property (
        (!eff_master && state_r.bp_cfg[BP_DERIVE_POS]) |=> !ctl.bclk_oe)
        else $error("derived slave drives bit clock pin");

    AST_DERIVE_FOLLOWS: assert property (
        (bp_fp != FP_HIGH_FULL) |=> ctl.derive == $past(state_r.bp_cfg[BP_DERIVE_POS]))
        else $error("clock derivation not following its bit");

    AST_DIFF_SLAVE: assert property (
        !eff_master |=> ctl.diff_clk == $past(state_r.bp_cfg[BP_TYPE_POS]))
        else $error("slave clock input type not followed");

    AST_DIFF_MASTER: assert property (
        eff_master |=> !ctl.diff_clk)
        else $error("clock input type active while master");

    AST_HOLD_SELECT: assert property (
        1'b1 |=> ctl.fast_hold == !$past(state_r.bp_cfg[BP_HOLD_POS]))
        else $error("hold timing not following hold bit");

    AST_LB_PULSE: assert property (
        1'b1 |=> local_frame_pulse_high == ($past(lb_fp) == FP_HIGH_FULL))
        else $error("local frame pulse type mismatch");

    AST_BP_OUT_COPY: assert property (
        1'b1 |=> backplane_serial_out == {STREAMS{$past(local_serial_input)}})
        else $error("local input not copied to backplane streams");

    AST_PIN_A_RELEASED: assert property (
        (general_pin_a_config != PIN_A_FAIL_IN) |=> !general_pin_a_oe)
        else $error("general pin A driven outside clock-failure role");

    COV_MASTER: cover property (state_r.bp_cfg[BP_MASTER_POS] ##1 ctl.dclk_oe);
    COV_TAKEOVER: cover property (!state_r.bp_cfg[BP_MASTER_POS] ##1 ctl.dclk_oe);
    COV_DIV4: cover property ((state_r.lb_cfg[LB_DIV_POS +: 2] == DIV_4) && bclk_rise);
    COV_RATE8: cover property (slots_per_frame == SLOTS_8M);
    COV_DIV2: cover property ((state_r.lb_cfg[LB_DIV_POS +: 2] == DIV_2) && bclk_rise);

endmodule

// file: test/tdmcfg_bp_model.sv
// backplane neighbour model: free-running bit clock and input streams
`timescale 1ns/1ns

module tdmcfg_bp_model
#(
    parameter int HALF = 4
)
(
    input  wire logic                         core_clk,
    output logic                              bit_clock,
    output logic [tdmcfg_pkg::STREAMS-1:0]    streams
);
    import tdmcfg_pkg::*;

    int cnt = 0;

    initial bit_clock = 1'b0;
    initial streams = '0;

    // ========================================
    // streams change only on the rising bit clock
    always @(posedge core_clk)
    begin
        if (cnt == HALF - 1)
        begin
            cnt <= 0;
            bit_clock <= ~bit_clock;
            if (!bit_clock)
                streams <= STREAMS'($urandom);
        end
        else
            cnt <= cnt + 1;
    end
endmodule

// file: test/tdmcfg_top_tb.sv
// self-checking bench for the bus timing configuration block
`timescale 1ns/1ns

module tdmcfg_top_tb;
    import tdmcfg_pkg::*;

    localparam int HALF  = 4;
    localparam int LIMIT = 30000;

    logic                 core_clk = 1'b0;
    logic                 rst = 1'b1;
    logic                 wb_cyc = 1'b0;
    logic                 wb_stb = 1'b0;
    logic                 wb_we = 1'b0;
    logic [7:0]           wb_adr = 8'h00;
    logic [3:0]           wb_sel = 4'h0;
    logic [31:0]          wb_wdat = 32'h0;
    logic [31:0]          wb_rdat;
    logic                 wb_ack;
    logic                 clk_fail = 1'b0;
    logic [1:0]           pin_cfg = 2'h0;
    logic                 loc_in = 1'b0;
    logic                 bclk;
    logic [STREAMS-1:0]   bp_in;
    tdmcfg_ctl_s          ctl;
    logic [1:0]           bp_smpl;
    logic [1:0]           lb_smpl;
    logic [7:0]           slots;
    logic                 lb_fph;
    logic                 pin_out;
    logic                 pin_oe;
    logic                 loc_clk;
    logic                 loc_out;
    logic [STREAMS-1:0]   bp_out;
    logic [STREAMS-1:0]   bp_oe;
    int                   err_count = 0;
    int                   n_compared = 0;
    int                   cycles = 0;

    tdmcfg_top i_tdmcfg_top (.core_clk(core_clk), .rst(rst), .wb_cyc_i(wb_cyc),
        .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
        .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
        .clock_failure_status(clk_fail), .general_pin_a_config(pin_cfg),
        .bit_clock_in(bclk), .backplane_serial_in(bp_in), .local_serial_input(loc_in),
        .ctl(ctl), .backplane_sample_point(bp_smpl), .local_sample_point(lb_smpl),
        .slots_per_frame(slots), .local_frame_pulse_high(lb_fph),
        .general_pin_a_out(pin_out), .general_pin_a_oe(pin_oe),
        .local_bit_clock(loc_clk), .local_serial_output(loc_out),
        .backplane_serial_out(bp_out), .backplane_serial_oe(bp_oe));

    tdmcfg_bp_model #(.HALF(HALF)) i_tdmcfg_bp_model (.core_clk(core_clk),
        .bit_clock(bclk), .streams(bp_in));

    always #50 core_clk = ~core_clk;

    // ========================================
    // run-length guard
    always @(posedge core_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == LIMIT)
        begin
            err_count++;
            tally_and_finish();
        end
    end

    // ========================================
    // helpers
    task automatic tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_compared++;
        if (seen !== exp)
        begin
            err_count++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d,
                      input logic [3:0] sel, output logic [31:0] rd);
        @(posedge core_clk);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= adr;
        wb_sel <= sel;
        wb_wdat <= d;
        do @(posedge core_clk); while (wb_ack !== 1'b1);
        rd = wb_rdat;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
    endtask

    task automatic loc_period(output int p);
        do @(posedge core_clk); while (loc_clk !== 1'b0);
        do @(posedge core_clk); while (loc_clk !== 1'b1);
        p = 0;
        do begin @(posedge core_clk); p++; end while (loc_clk !== 1'b0);
        do begin @(posedge core_clk); p++; end while (loc_clk !== 1'b1);
    endtask

    function automatic tdmcfg_ctl_s exp_ctl(logic [15:0] bp, logic [1:0] pc, logic cf);
        tdmcfg_ctl_s c;
        logic m;
        logic fph;
        m = bp[8] | (bp[9] & (pc == 2'h3) & cf);
        fph = (bp[1:0] == 2'h3);
        c.dclk_oe = m;
        c.bclk_oe = m;
        c.fp_oe = m;
        c.fp_high = fph;
        c.diff_clk = bp[7] & ~m;
        c.derive = bp[6] & ~(fph & ~m);
        c.fast_hold = ~bp[11];
        c.mc_en = ~fph;
        return c;
    endfunction

    function automatic logic [1:0] smp(logic [1:0] x);
        return (x == 2'h3) ? SMPL_END : x;
    endfunction

    function automatic logic [7:0] exp_slots(logic [1:0] r);
        return (r == RATE_4M) ? SLOTS_4M : (r == RATE_8M) ? SLOTS_8M : SLOTS_2M;
    endfunction

    // ========================================
    // main sequence
    initial
    begin
        logic [31:0] rd;
        logic [15:0] bp;
        logic [15:0] lb;
        logic [1:0]  pc;
        logic        cf;
        int          p;
        tdmcfg_ctl_s ec;
        void'($urandom(29247));
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        wb(1'b0, ADDR_BP_CFG, 32'h0, 4'h3, rd);
        check(rd, {16'h0, BP_CFG_RESET}, "bp reset");
        wb(1'b0, ADDR_LB_CFG, 32'h0, 4'h3, rd);
        check(rd, {16'h0, LB_CFG_RESET}, "lb reset");
        check(32'(slots), 32'(SLOTS_2M), "slots reset");
        for (int i = 0; i < 24; i++)
        begin
            bp = 16'($urandom);
            lb = 16'($urandom);
            pc = 2'($urandom);
            cf = 1'($urandom);
            if (i < 4)
            begin
                bp[5:0] = {3{i[1:0]}};
                lb[3:0] = {2{i[1:0]}};
                lb[7:6] = i[1:0];
            end
            if (i == 4 || i == 5)
            begin
                bp[9:8] = 2'b10;
                pc = 2'h3;
                cf = (i == 4);
            end
            bp[10] = 1'b0;
            lb[5:4] = 2'h0;
            clk_fail <= cf;
            pin_cfg <= pc;
            loc_in <= 1'($urandom);
            wb(1'b1, ADDR_BP_CFG, {16'h0, bp}, 4'h3, rd);
            wb(1'b1, ADDR_LB_CFG, {16'h0, lb}, 4'h3, rd);
            wb(1'b0, ADDR_BP_CFG, 32'h0, 4'h3, rd);
            check(rd, {20'h0, bp[11:0]}, "bp readback");
            wb(1'b0, ADDR_LB_CFG, 32'h0, 4'h3, rd);
            check(rd, {16'h0, lb}, "lb readback");
            loc_period(p);
            check(p, (2 * HALF) << ((lb[7:6] == 2'h3) ? 0 : lb[7:6]), "loc period");
            do @(posedge core_clk); while (bclk !== 1'b1);
            repeat (3) @(posedge core_clk);
            ec = exp_ctl(bp, pc, cf);
            check(32'(ctl), 32'(ec), "ctl");
            check(32'(bp_smpl), 32'(smp(bp[3:2])), "bp sample");
            check(32'(lb_smpl), 32'(smp(lb[3:2])), "lb sample");
            check(32'(slots), 32'(exp_slots(bp[5:4])), "slots");
            check(32'(lb_fph), 32'(lb[1:0] == 2'h3), "lb pulse");
            check({pin_oe, pin_out}, {pc == 2'h3 && ec.dclk_oe, 1'b0}, "pin a");
            check(32'(loc_out), 32'(bp_in[lb[11:8]]), "loc out");
            check(32'(bp_oe), 32'(16'h1 << lb[15:12]), "bp oe");
            check(32'(bp_out), 32'({STREAMS{loc_in}}), "bp out");
        end
        wb(1'b1, 8'h08, 32'h0000_ffff, 4'h3, rd);
        wb(1'b0, 8'h08, 32'h0, 4'h3, rd);
        check(rd, 32'h0, "unmapped read");
        wb(1'b0, ADDR_BP_CFG, 32'h0, 4'h3, rd);
        check(rd, {20'h0, bp[11:0]}, "bp after unmapped");
        wb(1'b1, ADDR_LB_CFG, 32'h0000_ffcf, 4'h2, rd);
        wb(1'b0, ADDR_LB_CFG, 32'h0, 4'h3, rd);
        check(rd, {16'h0, 8'hff, lb[7:0]}, "lane write");
        tally_and_finish();
    end
endmodule
